//--- logic/external_memory_space_decoder.sv
// External memory space decoder: overlay, I/O, byte and composite select strobes.
// Assumes pins mode_b, bus_grant and ext_data_in are asynchronous; core port is on aclk.
`timescale 1ns/1ps
module external_memory_space_decoder (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_b,
  input wire logic bus_grant,
  input wire logic acc_req,
  input wire logic [1:0] acc_space,
  input wire logic [13:0] acc_addr,
  input wire logic [7:0] acc_page,
  input wire logic acc_wr,
  input wire logic [23:0] acc_wdata,
  output logic acc_ready,
  output logic acc_done,
  output logic acc_fault,
  output logic [23:0] acc_rdata,
  input wire logic [12:0] fetch_addr,
  output logic [23:0] fetch_data,
  output logic int_prog_sel,
  output logic int_data_sel,
  output logic mmr_sel,
  output logic [13:0] ext_addr,
  output logic [23:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic [23:0] ext_data_in,
  output logic program_space_strobe_n,
  output logic data_space_strobe_n,
  output logic byte_space_strobe_n,
  output logic io_space_strobe_n,
  output logic composite_select_n
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [25:0] pin_m_q, pin_s_q;
  always_ff @(posedge aclk)
  begin
    pin_m_q <= {mode_b, bus_grant, ext_data_in};
    pin_s_q <= pin_m_q;
  end
  wire mode_b_s = pin_s_q[25];
  wire grant_s = pin_s_q[24];
  wire [23:0] din_s = pin_s_q[23:0];

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [1:0] povl_q, dovl_q;
  logic [2:0] data_wait_setting_q, pwait_q, bwait_q;
  logic [3:0][2:0] iow_q;
  logic [3:0] cs_en_q;
  logic byte_dis_q;
  mem_space_pkg::state_t state_q, state_d;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      mem_space_pkg::OFF_OVERLAY:
      begin
        r[mem_space_pkg::POVL_LSB +: 2] = povl_q;
        r[mem_space_pkg::DOVL_LSB +: 2] = dovl_q;
      end
      mem_space_pkg::OFF_WAIT:
      begin
        r[mem_space_pkg::DATA_WAIT_SETTING_LSB +: 3] = data_wait_setting_q;
        r[mem_space_pkg::PWAIT_LSB +: 3] = pwait_q;
        r[mem_space_pkg::BWAIT_LSB +: 3] = bwait_q;
      end
      mem_space_pkg::OFF_IO_WAIT: r[11:0] = iow_q;
      mem_space_pkg::OFF_CS_EN: r[3:0] = cs_en_q;
      mem_space_pkg::OFF_SYS_CTRL: r[mem_space_pkg::BYTE_DIS_BIT] = byte_dis_q;
      mem_space_pkg::OFF_STATUS: r[2:0] = {grant_s, state_q == mem_space_pkg::ST_ACTIVE, mode_b_s};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == mem_space_pkg::OFF_OVERLAY || a == mem_space_pkg::OFF_WAIT ||
           a == mem_space_pkg::OFF_IO_WAIT || a == mem_space_pkg::OFF_CS_EN ||
           a == mem_space_pkg::OFF_SYS_CTRL || a == mem_space_pkg::OFF_STATUS;
  endfunction

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q, awready_q, wready_q, arready_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  wire aw_hs = s_axi_awvalid & awready_q;
  wire w_hs = s_axi_wvalid & wready_q;
  wire ar_hs = s_axi_arvalid & arready_q;
  wire do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
  wire aw_hold_d = (aw_hold_q | aw_hs) & ~do_wr;
  wire w_hold_d = (w_hold_q | w_hs) & ~do_wr;
  wire bvalid_d = do_wr | (bvalid_q & ~s_axi_bready);
  wire rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wword = (reg_read(awaddr_q) & ~wmask) | (wdata_q & wmask);
  wire wr_ovl = do_wr && awaddr_q == mem_space_pkg::OFF_OVERLAY;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      bresp_q <= mem_space_pkg::RESP_OKAY;
      rresp_q <= mem_space_pkg::RESP_OKAY;
      rdata_q <= 32'h0;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      awready_q <= ~aw_hold_d & ~bvalid_d;
      wready_q <= ~w_hold_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
      if (aw_hs)
        awaddr_q <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr)
        bresp_q <= mapped(awaddr_q) ? mem_space_pkg::RESP_OKAY : mem_space_pkg::RESP_DECERR;
      if (ar_hs)
      begin
        rdata_q <= reg_read(s_axi_araddr);
        rresp_q <= mapped(s_axi_araddr) ? mem_space_pkg::RESP_OKAY : mem_space_pkg::RESP_DECERR;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      povl_q <= 2'h0;
      dovl_q <= 2'h0;
      data_wait_setting_q <= 3'h0;
      pwait_q <= 3'h0;
      bwait_q <= 3'h0;
      iow_q <= '0;
      cs_en_q <= mem_space_pkg::CS_EN_RST;
      byte_dis_q <= 1'b0;
    end
    else
    begin
      if (mode_b_s)
        povl_q <= 2'h0;
      else if (wr_ovl)
        povl_q <= wword[mem_space_pkg::POVL_LSB +: 2];
      if (wr_ovl)
        dovl_q <= wword[mem_space_pkg::DOVL_LSB +: 2];
      if (do_wr && awaddr_q == mem_space_pkg::OFF_WAIT)
      begin
        data_wait_setting_q <= wword[mem_space_pkg::DATA_WAIT_SETTING_LSB +: 3];
        pwait_q <= wword[mem_space_pkg::PWAIT_LSB +: 3];
        bwait_q <= wword[mem_space_pkg::BWAIT_LSB +: 3];
      end
      if (do_wr && awaddr_q == mem_space_pkg::OFF_IO_WAIT)
        iow_q <= wword[11:0];
      if (do_wr && awaddr_q == mem_space_pkg::OFF_CS_EN)
        cs_en_q <= wword[3:0];
      if (do_wr && awaddr_q == mem_space_pkg::OFF_SYS_CTRL)
        byte_dis_q <= wword[mem_space_pkg::BYTE_DIS_BIT];
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  wire hi_half = acc_addr[mem_space_pkg::HALF_BIT];
  wire povl_ok = povl_q == mem_space_pkg::OVL_EXT1 || povl_q == mem_space_pkg::OVL_EXT2;
  wire dovl_ok = dovl_q == mem_space_pkg::OVL_EXT1 || dovl_q == mem_space_pkg::OVL_EXT2;
  wire mem_space_pkg::kind_t kind_prog = mode_b_s ? (hi_half ? mem_space_pkg::K_RSVD : mem_space_pkg::K_EXT)
    : (!hi_half ? mem_space_pkg::K_INT : (povl_ok ? mem_space_pkg::K_EXT : mem_space_pkg::K_RSVD));
  wire mem_space_pkg::kind_t kind_data = hi_half
    ? (acc_addr >= mem_space_pkg::MMR_BASE ? mem_space_pkg::K_MMR : mem_space_pkg::K_INT)
    : (dovl_ok ? mem_space_pkg::K_EXT : mem_space_pkg::K_RSVD);
  wire mem_space_pkg::kind_t kind_nx = acc_space == mem_space_pkg::SP_PROG ? kind_prog
    : acc_space == mem_space_pkg::SP_DATA ? kind_data : mem_space_pkg::K_EXT;
  wire up_bit = acc_space == mem_space_pkg::SP_PROG ? (!mode_b_s && povl_q == mem_space_pkg::OVL_EXT2)
    : dovl_q == mem_space_pkg::OVL_EXT2;
  wire [13:0] xaddr_nx = acc_space == mem_space_pkg::SP_IO ? {3'h0, acc_addr[mem_space_pkg::IO_ADDR_W-1:0]}
    : acc_space == mem_space_pkg::SP_BYTE ? acc_addr : {up_bit, acc_addr[mem_space_pkg::LOW_BITS-1:0]};
  wire [2:0] io_wait = iow_q[acc_addr[mem_space_pkg::IO_REG_HI:mem_space_pkg::IO_REG_LO]];
  wire [2:0] wait_nx = acc_space == mem_space_pkg::SP_IO ? io_wait : acc_space == mem_space_pkg::SP_DATA ? data_wait_setting_q
    : acc_space == mem_space_pkg::SP_BYTE ? bwait_q : pwait_q;
  // byte lanes and upper address byte
  wire [23:0] xdata_nx = acc_space == mem_space_pkg::SP_BYTE ? {acc_page, acc_wdata[7:0], 8'h00} : acc_wdata;

  // ****************************************
  // Access sequencer and strobes
  // ****************************************
  logic [2:0] cnt_q;
  mem_space_pkg::kind_t kind_q;
  logic [1:0] space_q;
  logic wr_q, ready_q, done_q, fault_q, int_p_q, int_d_q, mmr_q, oe_q, cs_n_q;
  logic [3:0] strobe_n_q;
  logic [13:0] xaddr_q;
  logic [23:0] xdata_q, rd_q, fetch_q;
  logic [23:0] pram [mem_space_pkg::PRAM_DEPTH];
  wire start = acc_req & ready_q;
  wire last = state_q == mem_space_pkg::ST_ACTIVE && cnt_q == 3'h0;
  wire mem_space_pkg::kind_t kind_d = start ? kind_nx : kind_q;
  wire [1:0] space_d = start ? acc_space : space_q;
  wire wr_d = start ? acc_wr : wr_q;
  wire act_d = state_d == mem_space_pkg::ST_ACTIVE;
  wire ext_d = act_d && kind_d == mem_space_pkg::K_EXT;
  wire [3:0] sel_oh = ext_d ? 4'h1 << space_d : 4'h0;
  wire [3:0] byte_kill = {1'b0, byte_dis_q, 2'h0};
  wire int_prog_nx = start && kind_nx == mem_space_pkg::K_INT && acc_space == mem_space_pkg::SP_PROG;
  wire [12:0] pidx = acc_addr[mem_space_pkg::LOW_BITS-1:0];

  always_comb
  begin
    unique case (state_q)
      mem_space_pkg::ST_IDLE: state_d = start ? mem_space_pkg::ST_ACTIVE : mem_space_pkg::ST_IDLE;
      mem_space_pkg::ST_ACTIVE: state_d = last ? mem_space_pkg::ST_IDLE : mem_space_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= mem_space_pkg::ST_IDLE;
      cnt_q <= 3'h0;
      kind_q <= mem_space_pkg::K_INT;
      space_q <= mem_space_pkg::SP_PROG;
      wr_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
      int_p_q <= 1'b0;
      int_d_q <= 1'b0;
      mmr_q <= 1'b0;
      oe_q <= 1'b0;
      strobe_n_q <= 4'hF;
      cs_n_q <= 1'b1;
      xaddr_q <= 14'h0;
      xdata_q <= 24'h0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      space_q <= space_d;
      wr_q <= wr_d;
      if (start)
        cnt_q <= kind_nx == mem_space_pkg::K_EXT ? wait_nx : 3'h0;
      else if (state_q == mem_space_pkg::ST_ACTIVE && cnt_q != 3'h0)
        cnt_q <= cnt_q - 3'h1;
      ready_q <= !act_d && !grant_s;
      done_q <= last;
      fault_q <= last && kind_q == mem_space_pkg::K_RSVD;
      int_p_q <= act_d && kind_d == mem_space_pkg::K_INT && space_d == mem_space_pkg::SP_PROG;
      int_d_q <= act_d && kind_d == mem_space_pkg::K_INT && space_d == mem_space_pkg::SP_DATA;
      mmr_q <= act_d && kind_d == mem_space_pkg::K_MMR;
      oe_q <= ext_d && wr_d && !grant_s;
      strobe_n_q <= ~(sel_oh & ~byte_kill) | {4{grant_s}};
      cs_n_q <= ~(|(sel_oh & cs_en_q)) | grant_s;
      if (start)
      begin
        xaddr_q <= xaddr_nx;
        xdata_q <= xdata_nx;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    fetch_q <= pram[fetch_addr];
    if (int_prog_nx && acc_wr)
      pram[pidx] <= acc_wdata;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_q <= 24'h0;
    else if (int_prog_nx && !acc_wr)
      rd_q <= pram[pidx];
    else if (last && kind_q == mem_space_pkg::K_EXT && !wr_q)
      rd_q <= space_q == mem_space_pkg::SP_BYTE ? {16'h0, din_s[15:8]} : din_s;
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign acc_ready = ready_q;
  assign acc_done = done_q;
  assign acc_fault = fault_q;
  assign acc_rdata = rd_q;
  assign fetch_data = fetch_q;
  assign int_prog_sel = int_p_q;
  assign int_data_sel = int_d_q;
  assign mmr_sel = mmr_q;
  assign ext_addr = xaddr_q;
  assign ext_data_out = xdata_q;
  assign ext_data_oe = oe_q;
  assign program_space_strobe_n = strobe_n_q[mem_space_pkg::SP_PROG];
  assign data_space_strobe_n = strobe_n_q[mem_space_pkg::SP_DATA];
  assign byte_space_strobe_n = strobe_n_q[mem_space_pkg::SP_BYTE];
  assign io_space_strobe_n = strobe_n_q[mem_space_pkg::SP_IO];
  assign composite_select_n = cs_n_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_prog_ovl1;
    start && acc_space == mem_space_pkg::SP_PROG && !mode_b_s && hi_half && povl_q == mem_space_pkg::OVL_EXT1;
  endsequence
  sequence s_data_w3;
    start && acc_space == mem_space_pkg::SP_DATA && !hi_half && dovl_ok && data_wait_setting_q == 3'h3;
  endsequence
  property p_prog_ovl;
    s_prog_ovl1 |=> !ext_addr[13] && ext_addr[12:0] == $past(acc_addr[12:0]);
  endproperty
  a_prog_ovl: assert property (p_prog_ovl) else $error("program overlay address wrong");
  property p_mode_b_rsvd;
    start && acc_space == mem_space_pkg::SP_PROG && mode_b_s && hi_half |=> program_space_strobe_n ##1 acc_fault;
  endproperty
  a_mode_b_rsvd: assert property (p_mode_b_rsvd) else $error("mode B upper program not reserved");
  property p_mode_b_ovl;
    mode_b_s |=> povl_q == 2'h0;
  endproperty
  a_mode_b_ovl: assert property (p_mode_b_ovl) else $error("program overlay not held zero");
  property p_int_one;
    start && kind_nx == mem_space_pkg::K_INT |=> program_space_strobe_n ##1 acc_done;
  endproperty
  a_int_one: assert property (p_int_one) else $error("internal access not one cycle");
  property p_data_wait_setting;
    s_data_w3 |=> !acc_done [*4] ##1 acc_done;
  endproperty
  a_data_wait_setting: assert property (p_data_wait_setting) else $error("data wait stretch wrong");
  property p_io_region;
    start && acc_space == mem_space_pkg::SP_IO && acc_addr[10:9] == 2'h2 && iow_q[2] == 3'h5
      |=> !acc_done [*6] ##1 acc_done;
  endproperty
  a_io_region: assert property (p_io_region) else $error("I/O region wait wrong");
  property p_io_addr;
    start && acc_space == mem_space_pkg::SP_IO |=> ext_addr[10:0] == $past(acc_addr[10:0]);
  endproperty
  a_io_addr: assert property (p_io_addr) else $error("I/O address wrong");
  property p_data_map;
    start && acc_space == mem_space_pkg::SP_DATA && acc_addr >= mem_space_pkg::MMR_BASE |=> mmr_sel;
  endproperty
  a_data_map: assert property (p_data_map) else $error("control register window missed");
  property p_cs_follow;
    !program_space_strobe_n && $past(cs_en_q[0]) |-> !composite_select_n;
  endproperty
  a_cs_follow: assert property (p_cs_follow) else $error("composite select missed strobe");
  property p_grant;
    grant_s |=> composite_select_n && strobe_n_q == 4'hF;
  endproperty
  a_grant: assert property (p_grant) else $error("select driven under bus grant");
  property p_cs_rst;
    $rose(aresetn) |-> cs_en_q == mem_space_pkg::CS_EN_RST;
  endproperty
  a_cs_rst: assert property (p_cs_rst) else $error("composite enables reset wrong");
  property p_byte_addr;
    start && acc_space == mem_space_pkg::SP_BYTE |=> ext_data_out[23:16] == $past(acc_page);
  endproperty
  a_byte_addr: assert property (p_byte_addr) else $error("byte upper address wrong");
  property p_byte_dis;
    byte_dis_q && $past(byte_dis_q) |-> byte_space_strobe_n;
  endproperty
  a_byte_dis: assert property (p_byte_dis) else $error("byte strobe not disabled");
endmodule

//--- logic/mem_space_pkg.sv
// Constants for the external memory space decoder.
// Assumes one 125 MHz clock and an AXI4-Lite register port with 8-bit addresses.
package mem_space_pkg;
  // ****************************************
  // Widths and address map of the core spaces
  // ****************************************
  localparam int ADDR_W = 14;
  localparam int DATA_W = 24;
  localparam int PRAM_DEPTH = 8192;
  localparam int LOW_BITS = 13;
  localparam int HALF_BIT = 13;
  localparam int IO_ADDR_W = 11;
  localparam int IO_REG_HI = 10;
  localparam int IO_REG_LO = 9;
  localparam logic [13:0] MMR_BASE = 14'h3FE0;
  localparam logic [1:0] OVL_EXT1 = 2'h1;
  localparam logic [1:0] OVL_EXT2 = 2'h2;
  // ****************************************
  // Spaces (strobe bit order) and access kinds
  // ****************************************
  localparam logic [1:0] SP_PROG = 2'h0;
  localparam logic [1:0] SP_DATA = 2'h1;
  localparam logic [1:0] SP_BYTE = 2'h2;
  localparam logic [1:0] SP_IO = 2'h3;
  typedef enum logic [1:0] {K_INT = 2'h0, K_EXT = 2'h1, K_MMR = 2'h3, K_RSVD = 2'h2} kind_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_ACTIVE = 1'b1} state_t;
  // ****************************************
  // Register offsets, fields and reset values
  // ****************************************
  localparam logic [7:0] OFF_OVERLAY = 8'h00;
  localparam logic [7:0] OFF_WAIT = 8'h04;
  localparam logic [7:0] OFF_IO_WAIT = 8'h08;
  localparam logic [7:0] OFF_CS_EN = 8'h0C;
  localparam logic [7:0] OFF_SYS_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam int POVL_LSB = 0;
  localparam int DOVL_LSB = 4;
  localparam int DATA_WAIT_SETTING_LSB = 0;
  localparam int PWAIT_LSB = 4;
  localparam int BWAIT_LSB = 8;
  localparam int BYTE_DIS_BIT = 3;
  localparam logic [3:0] CS_EN_RST = 4'hB;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

//--- tb/ext_mem_model.sv
// External overlay, byte and I/O memory seen behind the space strobes.
// Assumes the decoder drives address, data and output enable from aclk.
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic aclk,
  input wire logic sel_n,
  input wire logic [13:0] ext_addr,
  input wire logic [23:0] ext_data_out,
  input wire logic ext_data_oe,
  output logic [23:0] ext_data_in
);
  logic [23:0] mem_q [0:255];
  logic [23:0] last_q = 24'h000000;
  wire rd_act = !sel_n && !ext_data_oe;
  always @(posedge aclk)
  begin
    if (!sel_n && ext_data_oe)
      mem_q[ext_addr[7:0]] <= ext_data_out;
    if (rd_act)
      last_q <= mem_q[ext_addr[7:0]];
  end
  // Released bus shows the inverse of the last value
  assign ext_data_in = rd_act ? mem_q[ext_addr[7:0]] : ~last_q;
endmodule

//--- tb/tb.sv
// Self-checking bench for the external memory space decoder.
// Assumes the decoder and the external memory model are compiled first.
`timescale 1ns/1ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
  logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic [31:0] w_data = 32'h00000000;
  logic mode_b = 1'b0, bus_grant = 1'b0, acc_req = 1'b0, acc_wr = 1'b0;
  logic [1:0] acc_space = 2'h0;
  logic [13:0] acc_addr = 14'h0000, ad;
  logic [7:0] acc_page = 8'h00;
  logic [23:0] acc_wdata = 24'h000000, last_wd;
  logic [12:0] fetch_addr = 13'h0000;
  logic [3:0] cs_en = 4'hB;
  logic [48:0] e;
  logic [33:0] r_q [$];
  logic [48:0] a_q [$];
  wire aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, acc_ready, acc_done, acc_fault, oe, cs_n;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_data;
  wire [23:0] acc_rdata, fetch_data, x_out, x_in;
  wire [13:0] x_addr;
  wire [3:0] stb_n;
  wire [2:0] isel;
  int err_count = 0, total_checks = 0, cycles = 0, seed = 15196;
  external_memory_space_decoder i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_addr), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_data), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_valid), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld), .s_axi_bready(b_ready),
    .s_axi_araddr(ar_addr), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld), .s_axi_rready(r_ready),
    .mode_b(mode_b), .bus_grant(bus_grant), .acc_req(acc_req), .acc_space(acc_space), .acc_addr(acc_addr),
    .acc_page(acc_page), .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_ready(acc_ready), .acc_done(acc_done),
    .acc_fault(acc_fault), .acc_rdata(acc_rdata), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
    .int_prog_sel(isel[0]), .int_data_sel(isel[1]), .mmr_sel(isel[2]), .ext_addr(x_addr),
    .ext_data_out(x_out), .ext_data_oe(oe), .ext_data_in(x_in),
    .program_space_strobe_n(stb_n[0]), .data_space_strobe_n(stb_n[1]), .byte_space_strobe_n(stb_n[2]),
    .io_space_strobe_n(stb_n[3]), .composite_select_n(cs_n));
  ext_mem_model i_mem (.aclk(aclk), .sel_n(&stb_n), .ext_addr(x_addr), .ext_data_out(x_out),
    .ext_data_oe(oe), .ext_data_in(x_in));
  always #4 aclk = ~aclk;
  task automatic chk(input logic [48:0] got, input logic [48:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  // ****************************************
  // Result watcher and composite select watch
  // ****************************************
  always @(posedge aclk)
  begin
    if (r_vld && r_ready)
      chk({r_resp, r_data}, r_q.pop_front());
    if (acc_done)
    begin
      e = a_q.pop_front();
      chk({acc_fault, acc_rdata & e[47:24]}, {e[48], e[23:0]});
    end
    if (aresetn)
      chk(cs_n, ~|(~stb_n & cs_en));
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_pend, w_pend;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    while (aw_pend || w_pend)
    begin
      @(posedge aclk);
      if (aw_pend && aw_rdy)
      begin
        aw_pend = 1'b0;
        aw_valid <= 1'b0;
      end
      if (w_pend && w_rdy)
      begin
        w_pend = 1'b0;
        w_valid <= 1'b0;
      end
    end
    b_ready <= 1'b1;
    do @(posedge aclk); while (!b_vld);
    b_ready <= 1'b0;
    chk(b_resp, mem_space_pkg::RESP_OKAY);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] x);
    r_q.push_back(x);
    ar_addr <= a;
    ar_valid <= 1'b1;
    do @(posedge aclk); while (!ar_rdy);
    ar_valid <= 1'b0;
    r_ready <= 1'b1;
    do @(posedge aclk); while (!r_vld);
    r_ready <= 1'b0;
  endtask
  task automatic acc(input logic [1:0] sp, input logic [13:0] a, input logic wr, input logic [3:0] s,
      input logic [2:0] sl, input int w, input logic [48:0] x, input logic [13:0] xa);
    logic [7:0] pg;
    logic [23:0] wd;
    int n;
    pg = $random(seed);
    wd = $random(seed);
    last_wd = wd;
    acc_space <= sp;
    acc_addr <= a;
    acc_wr <= wr;
    acc_page <= pg;
    acc_wdata <= wd;
    acc_req <= 1'b1;
    do @(posedge aclk); while (!acc_ready);
    acc_req <= 1'b0;
    a_q.push_back(x);
    #1;
    chk({~stb_n, isel}, {s, sl});
    if (s != 4'h0)
      chk(x_addr, xa);
    if (s[2] && wr)
      chk(x_out[23:8], {pg, wd[7:0]});
    n = 0;
    while (!acc_done && n < 20)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
    chk(n, w + 1);
    @(posedge aclk);
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(mem_space_pkg::OFF_CS_EN, {2'h0, 28'h0000000, 4'hB});
    axi_rd(8'hFC, {mem_space_pkg::RESP_DECERR, 32'h00000000});
    axi_wr(mem_space_pkg::OFF_CS_EN, 32'h00000003);
    cs_en = 4'h3;
    axi_wr(mem_space_pkg::OFF_WAIT, 32'h00000333);
    axi_wr(mem_space_pkg::OFF_IO_WAIT, 32'h00000F59);
    $display("test registers done");
    for (int v = 1; v <= 2; v++)
    begin
      axi_wr(mem_space_pkg::OFF_OVERLAY, v);
      ad = 14'h2000 | 14'($random(seed) & 255);
      acc(2'h0, ad, 1'b1, 4'h1, 3'h0, 3, 49'h0, {1'(v - 1), ad[12:0]});
      acc(2'h0, ad, 1'b0, 4'h1, 3'h0, 3, {1'b0, 24'hFFFFFF, last_wd}, {1'(v - 1), ad[12:0]});
      axi_wr(mem_space_pkg::OFF_OVERLAY, v << 4);
      ad = 14'($random(seed) & 255);
      acc(2'h1, ad, 1'b1, 4'h2, 3'h0, 3, 49'h0, {1'(v - 1), ad[12:0]});
      acc(2'h1, ad, 1'b0, 4'h2, 3'h0, 3, {1'b0, 24'h00FFFF, last_wd & 24'h00FFFF}, {1'(v - 1), ad[12:0]});
    end
    axi_wr(mem_space_pkg::OFF_OVERLAY, 32'h00000000);
    acc(2'h0, 14'h2100, 1'b0, 4'h0, 3'h0, 0, {1'b1, 48'h0}, 14'h0000);
    acc(2'h1, 14'h0100, 1'b0, 4'h0, 3'h0, 0, {1'b1, 48'h0}, 14'h0000);
    acc(2'h1, 14'h3FDF, 1'b0, 4'h0, 3'h2, 0, 49'h0, 14'h0000);
    acc(2'h1, 14'h3FE0, 1'b0, 4'h0, 3'h4, 0, 49'h0, 14'h0000);
    ad = 14'($random(seed) & 16'h1FFF);
    acc(2'h0, ad, 1'b1, 4'h0, 3'h1, 0, 49'h0, 14'h0000);
    fetch_addr <= ad[12:0];
    repeat (2) @(posedge aclk);
    chk(fetch_data, last_wd);
    acc(2'h0, ad, 1'b0, 4'h0, 3'h1, 0, {1'b0, 24'hFFFFFF, last_wd}, 14'h0000);
    $display("test overlay and internal done");
    for (int n = 0; n < 4; n++)
    begin
      ad = 14'(n * 512 + ($random(seed) & 511));
      acc(2'h3, ad, 1'b1, 4'h8, 3'h0, 2 * n + 1, 49'h0, {3'h0, ad[10:0]});
    end
    ad = 14'($random(seed) & 255);
    acc(2'h2, ad, 1'b1, 4'h4, 3'h0, 3, 49'h0, ad);
    acc(2'h2, ad, 1'b0, 4'h4, 3'h0, 3, {1'b0, 24'h0000FF, 16'h0000, last_wd[7:0]}, ad);
    axi_wr(mem_space_pkg::OFF_SYS_CTRL, 32'h00000008);
    acc(2'h2, ad, 1'b1, 4'h0, 3'h0, 3, 49'h0, ad);
    $display("test io and byte done");
    bus_grant <= 1'b1;
    repeat (4) @(posedge aclk);
    #1;
    chk({acc_ready, stb_n, cs_n}, 6'h1F);
    @(posedge aclk);
    bus_grant <= 1'b0;
    mode_b <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_wr(mem_space_pkg::OFF_OVERLAY, 32'h00000001);
    axi_rd(mem_space_pkg::OFF_OVERLAY, {2'h0, 32'h00000000});
    acc(2'h0, 14'h0040, 1'b1, 4'h1, 3'h0, 3, 49'h0, 14'h0040);
    acc(2'h0, 14'h2040, 1'b0, 4'h0, 3'h0, 0, {1'b1, 48'h0}, 14'h0000);
    $display("test grant and mode done");
    end_sim();
  end
endmodule
